// ### reset_watchdog_sleep_control.sv
/*
  Reset, watchdog and sleep control block: reset cause recording,
  power-on hold, sleep timer and watchdog, sleep entry and wake.
  Assumes lp_tick_rise/lp_tick_fall are one-cycle pulses from the
  32 kHz oscillator edges, core_clk_rise/fall likewise from the core
  clock, all synchronous to clk_sys.
*/
`timescale 1ns/100ps
`include "rwsc_params.svh"

module reset_watchdog_sleep_control
  import rwsc_pkg::*;
#(
  parameter int POR_HOLD = `POR_HOLD_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ext_reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // timing inputs
  input wire logic lp_tick_rise,
  input wire logic lp_tick_fall,
  input wire logic core_clk_rise,
  input wire logic core_clk_fall,
  // core side
  input wire logic global_irq_enable,
  input wire logic irq_pending_unmasked,
  input wire logic bus_request_ack,
  output logic bus_request_to_core,
  output logic core_run,
  output logic core_halted,
  output logic [15:0] fetch_addr,
  output logic clk_select_internal,
  output logic [2:0] cpu_speed,
  output logic irq_disable_all,
  output logic sleep_timer_irq,
  output logic watchdog_reset_event,
  // power control
  output logic system_power_down
);

  // ****************************************
  // register state
  // ****************************************
  logic wdr_flag;
  logic por_flag;
  logic sleep_bit;
  logic stop_bit;
  logic [1:0] sleep_sel;
  logic [1:0] watchdog_counter;
  logic [15:0] sleep_timer;
  logic [21:0] por_count;
  logic [1:0] recover_count;
  logic read_hit;
  logic [7:0] read_mux;
  sleep_state_t state;
  logic [15:0] st_top;
  logic st_ovf;
  logic wr_scr;
  logic wr_clr;
  logic wdt_fire;

  assign wr_scr = reg_write && (reg_addr == `OFS_SYSTEM_STATUS_CONTROL);
  assign wr_clr = reg_write && (reg_addr == `OFS_WATCHDOG_CLEAR);

  // ****************************************
  // status and control register
  // ****************************************
  // flags: hardware sets beat software clears
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      por_flag <= 1'b1;
      wdr_flag <= 1'b0;
    end
    else
    begin
      if (wr_scr && !reg_wdata[`SCR_BIT_POR])
        por_flag <= 1'b0;
      if (wdt_fire)
        wdr_flag <= 1'b1;
      else if (wr_scr && !reg_wdata[`SCR_BIT_WDR])
        wdr_flag <= 1'b0;
    end
  end

  // sleep and stop bits; a watchdog reset clears them like any reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sleep_bit <= 1'b0;
      stop_bit <= 1'b0;
      sleep_sel <= 2'h0;
    end
    else if (wdt_fire || ext_reset)
    begin
      sleep_bit <= 1'b0;
      stop_bit <= 1'b0;
      sleep_sel <= 2'h0;
    end
    else
    begin
      if (wr_scr)
      begin
        sleep_bit <= reg_wdata[`SCR_BIT_SLEEP];
        stop_bit <= reg_wdata[`SCR_BIT_STOP] | stop_bit;
      end
      else if (state == ST_WAKE_RECOVER && recover_count == 2'h0)
        sleep_bit <= 1'b0;
      if (reg_write && reg_addr == `OFS_SLEEP_TIMER_CFG)
        sleep_sel <= reg_wdata[1:0];
    end
  end

  // read mux, data registered one cycle later
  always_comb
  begin
    read_hit = 1'b1;
    read_mux = 8'h00;
    case (reg_addr)
      `OFS_SYSTEM_STATUS_CONTROL:
        read_mux = {global_irq_enable, 1'b0, wdr_flag, por_flag, sleep_bit,
          2'b00, stop_bit};
      `OFS_SLEEP_TIMER_CFG:
        read_mux = {6'h00, sleep_sel};
      default:
        read_hit = 1'b0; // unmapped and write-only read as zero
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_read && read_hit)
      reg_rdata <= read_mux;
    else
      reg_rdata <= 8'h00;
  end

  // ****************************************
  // sleep timer and watchdog
  // ****************************************
  // divide 32 kHz ticks: 64, 512, 4096, 32768 ticks per overflow
  always_comb
  begin
    case (sleep_sel)
      2'h0: st_top = 16'h003F;
      2'h1: st_top = 16'h01FF;
      2'h2: st_top = 16'h0FFF;
      default: st_top = 16'h7FFF;
    endcase
  end

  assign st_ovf = lp_tick_rise && (sleep_timer >= st_top);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      sleep_timer <= 16'h0000;
    else if (wr_clr && reg_wdata == `WDT_CLEAR_KEY)
      sleep_timer <= 16'h0000;
    else if (lp_tick_rise)
      sleep_timer <= st_ovf ? 16'h0000 : sleep_timer + 16'h0001;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      sleep_timer_irq <= 1'b0;
    else
      sleep_timer_irq <= st_ovf;
  end

  // watchdog held off until the power-on flag is cleared
  assign wdt_fire = !por_flag && st_ovf && !wr_clr
    && (watchdog_counter == `WDT_LIMIT - 2'h1);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      watchdog_counter <= 2'h0;
    else if (wr_clr || por_flag || wdt_fire)
      watchdog_counter <= 2'h0;
    else if (st_ovf)
      watchdog_counter <= watchdog_counter + 2'h1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      watchdog_reset_event <= 1'b0;
    else
      watchdog_reset_event <= wdt_fire;
  end

  // ****************************************
  // power-on hold and sleep sequence
  // ****************************************
  // hold counter also reused nowhere else; kept wide for 20 ms at 40 MHz
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      por_count <= 22'h000000;
    else if (state == ST_POR_HOLD)
      por_count <= por_count + 22'h000001;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      recover_count <= 2'h0;
    else if (state == ST_WAKE_SYNC)
      recover_count <= 2'(`WAKE_RECOVERY_LP_CYCLES - 1);
    else if (state == ST_WAKE_RECOVER && lp_tick_rise && recover_count != 2'h0)
      recover_count <= recover_count - 2'h1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state <= ST_POR_HOLD;
    else if (wdt_fire || ext_reset)
      state <= ST_RUN;
    else
    begin
      case (state)
        ST_POR_HOLD:
          if (por_count == 22'(POR_HOLD - 1))
            state <= ST_RUN;
        ST_RUN:
          if (wr_scr && reg_wdata[`SCR_BIT_SLEEP])
            state <= ST_REQ;
        ST_REQ:
          if (bus_request_ack)
            state <= ST_WAIT_FALL;
        ST_WAIT_FALL:
          if (core_clk_fall)
            state <= ST_ASLEEP;
        ST_ASLEEP:
          if (lp_tick_fall && irq_pending_unmasked && !stop_bit)
            state <= ST_WAKE_SYNC;
        ST_WAKE_SYNC:
          if (lp_tick_rise)
            state <= ST_WAKE_RECOVER;
        ST_WAKE_RECOVER:
          if (recover_count == 2'h0 && lp_tick_fall)
            state <= ST_RUN;
        default:
          state <= ST_RUN;
      endcase
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // request rises the cycle after the sleep write and holds until wake ends
  assign bus_request_to_core = (state == ST_REQ) || (state == ST_WAIT_FALL)
    || (state == ST_ASLEEP) || (state == ST_WAKE_SYNC)
    || (state == ST_WAKE_RECOVER);
  assign system_power_down = (state == ST_ASLEEP) || (state == ST_WAKE_SYNC);
  assign core_halted = stop_bit;
  // resuming without a vector jump gives the next instruction first
  assign core_run = (state == ST_RUN) && !stop_bit;
  assign fetch_addr = `FETCH_RESET_ADDR;
  assign clk_select_internal = 1'b1;
  assign cpu_speed = `CPU_SPEED_RESET;
  assign irq_disable_all = (state == ST_POR_HOLD);

  // ****************************************
  // checks
  // ****************************************
  sequence s_sleep_write;
    state == ST_RUN && wr_scr && reg_wdata[`SCR_BIT_SLEEP];
  endsequence

  a_sleep_request: assert property (@(posedge clk_sys) disable iff (rst)
    s_sleep_write |=> bus_request_to_core)
    else $error("bus request missing after sleep write");

  a_pd_after_fall: assert property (@(posedge clk_sys) disable iff (rst)
    (state == ST_WAIT_FALL && core_clk_fall && !wdt_fire && !ext_reset)
    |=> system_power_down)
    else $error("power-down not raised on core clock fall");

  a_no_pd_early: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(system_power_down) |-> $past(core_clk_fall))
    else $error("power-down rose without core clock fall");

  a_wdt_por_gate: assert property (@(posedge clk_sys) disable iff (rst)
    por_flag |-> !wdt_fire && watchdog_counter == 2'h0)
    else $error("watchdog active while power-on flag set");

  a_wdr_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
    wdt_fire |=> wdr_flag && watchdog_reset_event)
    else $error("watchdog flag not set");

  a_por_never_set: assert property (@(posedge clk_sys) disable iff (rst)
    !por_flag |=> !por_flag)
    else $error("power-on flag set by software");

  a_wdt_clear: assert property (@(posedge clk_sys) disable iff (rst)
    wr_clr |=> watchdog_counter == 2'h0)
    else $error("watchdog count not cleared");

  a_key_clears_st: assert property (@(posedge clk_sys) disable iff (rst)
    wr_clr && reg_wdata == `WDT_CLEAR_KEY |=> sleep_timer == 16'h0000)
    else $error("sleep timer not cleared by key");

  a_stop_blocks_wake: assert property (@(posedge clk_sys) disable iff (rst)
    state == ST_ASLEEP && stop_bit && !wdt_fire && !ext_reset
    |=> state == ST_ASLEEP)
    else $error("woke with halt bit set");

  a_gie_mirror: assert property (@(posedge clk_sys) disable iff (rst)
    reg_read && reg_addr == `OFS_SYSTEM_STATUS_CONTROL
    |=> reg_rdata[`SCR_BIT_GIE] == $past(global_irq_enable))
    else $error("global enable mirror wrong");

endmodule : reset_watchdog_sleep_control

// ### rwsc_params.svh
/*
  Constants for the reset, watchdog and sleep controller: register
  offsets, field positions, reset values and timing counts.
  Assumes a 40 MHz system clock and a 32 kHz low power tick input.
*/
`ifndef RWSC_PARAMS_SVH
`define RWSC_PARAMS_SVH

// ****************************************
// register map
// ****************************************
`define OFS_WATCHDOG_CLEAR 8'hE3
`define OFS_SYSTEM_STATUS_CONTROL 8'hFF
`define OFS_SLEEP_TIMER_CFG 8'hE4
`define SCR_RESET 8'h10
`define SCR_BIT_GIE 7
`define SCR_BIT_WDR 5
`define SCR_BIT_POR 4
`define SCR_BIT_SLEEP 3
`define SCR_BIT_STOP 0
`define WDT_CLEAR_KEY 8'h38
`define WDT_LIMIT 2'h3
`define FETCH_RESET_ADDR 16'h0000
`define CPU_SPEED_RESET 3'h0

// ****************************************
// timing
// ****************************************
`define CLK_HZ 40000000
`define POR_HOLD_MS 20
`define POR_HOLD_CYCLES ((`CLK_HZ / 1000) * `POR_HOLD_MS)
`define WAKE_RECOVERY_LP_CYCLES 3

`endif

// ### rwsc_pkg.sv
/*
  Types shared by the reset, watchdog and sleep controller.
  Assumes nothing beyond the params header.
*/
package rwsc_pkg;
  typedef enum logic [2:0] {
    ST_POR_HOLD,
    ST_RUN,
    ST_REQ,
    ST_WAIT_FALL,
    ST_ASLEEP,
    ST_WAKE_SYNC,
    ST_WAKE_RECOVER
  } sleep_state_t;
endpackage : rwsc_pkg

// ### core_model.sv
/*
  Core-side partner: makes the core clock edge pulses and answers the
  sleep bus request. Assumes one clk_sys domain, active-high rst.
*/
`timescale 1ns/100ps
module core_model
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // sleep handshake
  input wire logic bus_request_to_core,
  output logic bus_request_ack,
  // core clock edges
  output logic core_clk_rise,
  output logic core_clk_fall
);
  logic [2:0] phase;
  logic seen;
  // ****************************************
  // core clock is clk_sys over eight
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst) phase <= 3'h0;
    else phase <= phase + 3'h1;
  end
  // rise and fall half a core period apart, never together
  assign core_clk_rise = (phase == 3'h7);
  assign core_clk_fall = (phase == 3'h3);
  // request sampled on one core rise, acknowledged on the next
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      seen <= 1'b0;
      bus_request_ack <= 1'b0;
    end
    else if (core_clk_rise)
    begin
      seen <= bus_request_to_core;
      bus_request_ack <= seen & bus_request_to_core;
    end
  end
endmodule : core_model

// ### reset_watchdog_sleep_control_tb_top.sv
/*
  Self-checking bench for the reset, watchdog and sleep controller.
  Assumes core_model as the core; the 32 kHz ticks are sped up to one
  per 16 clocks so watchdog periods fit a short run.
*/
`timescale 1ns/100ps
`include "rwsc_params.svh"
module reset_watchdog_sleep_control_tb_top;
  logic clk_sys = 1'b0, rst = 1'b1, ext_reset = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic reg_write = 1'b0, reg_read = 1'b0, rd_d = 1'b0;
  logic lp_tick_rise = 1'b0, lp_tick_fall = 1'b0;
  logic global_irq_enable = 1'b0, irq_pending_unmasked = 1'b0;
  logic bus_request_ack, bus_request_to_core, core_run, core_halted;
  logic clk_select_internal, irq_disable_all, sleep_timer_irq;
  logic watchdog_reset_event, system_power_down, core_clk_rise, core_clk_fall;
  logic [15:0] fetch_addr;
  logic [2:0] cpu_speed;
  logic [3:0] lp_cnt = 4'h0;
  logic [7:0] exp_q[$];
  int err_total = 0, compares = 0, n = 0, irq_cnt = 0, wdr_cnt = 0;

  reset_watchdog_sleep_control #(.POR_HOLD(20)) reset_watchdog_sleep_control_inst (
    .clk_sys(clk_sys), .rst(rst), .ext_reset(ext_reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .lp_tick_rise(lp_tick_rise), .lp_tick_fall(lp_tick_fall),
    .core_clk_rise(core_clk_rise), .core_clk_fall(core_clk_fall),
    .global_irq_enable(global_irq_enable), .irq_pending_unmasked(irq_pending_unmasked),
    .bus_request_ack(bus_request_ack), .bus_request_to_core(bus_request_to_core),
    .core_run(core_run), .core_halted(core_halted), .fetch_addr(fetch_addr),
    .clk_select_internal(clk_select_internal), .cpu_speed(cpu_speed),
    .irq_disable_all(irq_disable_all), .sleep_timer_irq(sleep_timer_irq),
    .watchdog_reset_event(watchdog_reset_event), .system_power_down(system_power_down));
  core_model core_model_inst (.clk_sys(clk_sys), .rst(rst),
    .bus_request_to_core(bus_request_to_core), .bus_request_ack(bus_request_ack),
    .core_clk_rise(core_clk_rise), .core_clk_fall(core_clk_fall));

  // ****************************************
  // clock, ticks and monitors
  // ****************************************
  always #12.5 clk_sys = ~clk_sys;
  // fast stand-in for the low power oscillator edges
  always @(posedge clk_sys)
  begin
    lp_cnt <= lp_cnt + 4'h1;
    lp_tick_rise <= (lp_cnt == 4'hF);
    lp_tick_fall <= (lp_cnt == 4'h7);
    rd_d <= reg_read;
    if (sleep_timer_irq === 1'b1) irq_cnt++;
    if (watchdog_reset_event === 1'b1) wdr_cnt++;
  end
  // read data only stands in the cycle after the strobe
  always @(negedge clk_sys)
  begin
    if (rd_d === 1'b1) check(reg_rdata, exp_q.pop_front());
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(exp);
    @(posedge clk_sys);
    reg_read <= 1'b0;
  endtask : rd
  task automatic end_of_test();
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // hang guard: the whole sequence needs about 12000 clocks
  initial
  begin
    #(30000 * 25);
    err_total++;
    end_of_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    void'($urandom(32'he91b));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check(core_run, 1'b0);
    check(irq_disable_all, 1'b1);
    for (n = 0; n < 60 && core_run !== 1'b1; n++) @(negedge clk_sys);
    check(n >= 15 && n < 60, 1'b1);
    check(fetch_addr, `FETCH_RESET_ADDR);
    check(clk_select_internal, 1'b1);
    check(cpu_speed, `CPU_SPEED_RESET);
    check(irq_disable_all, 1'b0);
    rd(`OFS_SYSTEM_STATUS_CONTROL, `SCR_RESET);
    global_irq_enable <= 1'b1;
    wr(`OFS_SYSTEM_STATUS_CONTROL, 8'h30);
    rd(`OFS_SYSTEM_STATUS_CONTROL, 8'h90);
    rd(`OFS_WATCHDOG_CLEAR, 8'h00);
    rd(8'h12, 8'h00);
    // por flag still set: timer runs, watchdog must not
    for (n = 0; n < 4000; n++) @(negedge clk_sys);
    check(wdr_cnt, 0);
    check(irq_cnt >= 3, 1'b1);
    wr(`OFS_SYSTEM_STATUS_CONTROL, 8'h00);
    rd(`OFS_SYSTEM_STATUS_CONTROL, 8'h80);
    wr(`OFS_WATCHDOG_CLEAR, `WDT_CLEAR_KEY);
    // feed faster than one overflow, with keys that never hit 0x38
    repeat (12)
    begin
      d = 8'($urandom) & 8'hF7;
      wr(`OFS_WATCHDOG_CLEAR, d);
      repeat (400) @(posedge clk_sys);
    end
    check(wdr_cnt, 0);
    wr(`OFS_WATCHDOG_CLEAR, `WDT_CLEAR_KEY);
    for (n = 0; n < 3400 && wdr_cnt == 0; n++) @(negedge clk_sys);
    check(n > 2900 && n < 3300, 1'b1);
    for (n = 0; n < 100 && core_run !== 1'b1; n++) @(negedge clk_sys);
    wr(`OFS_WATCHDOG_CLEAR, `WDT_CLEAR_KEY);
    rd(`OFS_SYSTEM_STATUS_CONTROL, 8'hA0);
    // sleep entry with global enable off, then wake on a pending irq
    global_irq_enable <= 1'b0;
    // bit 5 written as 1 so the watchdog flag survives the sleep write
    wr(`OFS_SYSTEM_STATUS_CONTROL, 8'h28);
    @(negedge clk_sys);
    check(bus_request_to_core, 1'b1);
    for (n = 0; n < 40 && system_power_down !== 1'b1; n++) @(negedge clk_sys);
    check(bus_request_ack, 1'b1);
    check(system_power_down, 1'b1);
    @(posedge clk_sys);
    irq_pending_unmasked <= 1'b1;
    for (n = 0; n < 40 && system_power_down !== 1'b0; n++) @(negedge clk_sys);
    check(system_power_down, 1'b0);
    for (n = 0; n < 100 && core_run !== 1'b1; n++) @(negedge clk_sys);
    // three low power periods from the syncing fall, less the half of one before power-down drops
    check(n, `WAKE_RECOVERY_LP_CYCLES * 16 - 8);
    check(clk_select_internal, 1'b1);
    @(posedge clk_sys);
    irq_pending_unmasked <= 1'b0;
    rd(`OFS_SYSTEM_STATUS_CONTROL, 8'h20);
    // another timer select; the external reset must bring it back to 00
    wr(`OFS_SLEEP_TIMER_CFG, 8'h02);
    rd(`OFS_SLEEP_TIMER_CFG, 8'h02);
    // sleep with the halt bit set: a pending irq must not wake it
    wr(`OFS_SYSTEM_STATUS_CONTROL, 8'h29);
    repeat (30) @(negedge clk_sys);
    check(core_halted, 1'b1);
    check(system_power_down, 1'b1);
    @(posedge clk_sys);
    irq_pending_unmasked <= 1'b1;
    repeat (40) @(negedge clk_sys);
    check(system_power_down, 1'b1);
    check(core_run, 1'b0);
    @(posedge clk_sys);
    ext_reset <= 1'b1;
    irq_pending_unmasked <= 1'b0;
    @(posedge clk_sys);
    ext_reset <= 1'b0;
    repeat (3) @(negedge clk_sys);
    check(core_halted, 1'b0);
    rd(`OFS_SYSTEM_STATUS_CONTROL, 8'h20);
    rd(`OFS_SLEEP_TIMER_CFG, 8'h00);
    repeat (4) @(posedge clk_sys);
    end_of_test();
  end
endmodule : reset_watchdog_sleep_control_tb_top
